// *** rtl/ccrb_pkg.sv ***
// Shared constants for the codec control register bank
package ccrb_pkg;

  localparam int NREG = 12;

  // Register indices into the bank array
  localparam int IDX_TIMEOUT = 0;
  localparam int IDX_IF_CTRL = 1;
  localparam int IDX_RATE_SPLIT = 2;
  localparam int IDX_SAMPLE_RATE = 3;
  localparam int IDX_ADDR_CFG = 4;
  localparam int IDX_PUMP = 5;
  localparam int IDX_MIX_L = 6;
  localparam int IDX_MIX_R = 7;
  localparam int IDX_IO_LEVEL = 8;
  localparam int IDX_GAIN_RAMP = 9;
  localparam int IDX_SYNC = 10;
  localparam int IDX_THRESHOLD = 11;

  // Register offsets, index 0 in the low byte
  localparam logic [NREG-1:0][7:0] REG_OFS = {
    8'h95, 8'h94, 8'h92, 8'h91, 8'h6f, 8'h6e, 8'h47, 8'h1b, 8'h17, 8'h16, 8'h13, 8'h12};
  // Storable bits; reserved positions are never stored and read as zero
  localparam logic [NREG-1:0][7:0] REG_MASK = {
    8'h3f, 8'h03, 8'h03, 8'h01, 8'h80, 8'h80, 8'hb0, 8'h03, 8'h0f, 8'h01, 8'h01, 8'h01};
  // Values after reset and after a soft reset
  localparam logic [NREG-1:0][7:0] REG_RST = {
    8'h0e, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h02, 8'h0a, 8'h00, 8'h00, 8'h00};

  // Field positions
  localparam int MIX_EN_BIT = 7;
  localparam int IO_LEVEL_BIT = 0;
  localparam int PUMP_EN_BIT = 7;
  localparam int TRACK_LSB = 4;
  localparam int TRACK_MSB = 5;
  localparam int THRESH_MSB = 5;
  localparam int ADDR_CFG_MSB = 1;
  localparam int TIMEOUT_EN_BIT = 0;
  localparam int SOFT_RESET_BIT = 7;
  localparam int WRITE_MODE_BIT = 0;
  localparam int RATE_SPLIT_BIT = 0;
  localparam int RATE_MSB = 3;
  localparam int RAMP_MSB = 1;
  localparam int SYNC_MSB = 1;

  // Bus stall timeout: time in microseconds, clock in MHz
  localparam int TIMEOUT_US = 43900;
  localparam int CLK_MHZ = 100;
  localparam int TIMEOUT_CYCLES = TIMEOUT_US * CLK_MHZ;
  localparam int TO_W = 23;

  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV_ADDR, ST_DEV_ACK, ST_REG_ADDR, ST_REG_ACK,
    ST_WR_DATA, ST_WR_ACK, ST_RD_DATA, ST_RD_ACK
  } ccrb_state_t;

endpackage : ccrb_pkg

// *** rtl/ccrb_sync.sv ***
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ns
module ccrb_sync #(
  parameter int W = 2
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] filt;
  } ccrb_sync_state_t;

  ccrb_sync_state_t q_r;
  ccrb_sync_state_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = async_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    // Take the new level only when stages two and three agree
    q_nxt.filt = (q_r.s2 & q_r.s3) | (q_r.filt & (q_r.s2 ^ q_r.s3));
  end

  // Idle bus lines are high, so start from all ones
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r <= '1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign level_out = q_r.filt;

endmodule : ccrb_sync

// *** rtl/ccrb_bank.sv ***
// Codec control register bank with its two-wire serial slave
//
// Functional notes
// - Left and right mixer enables at bit 7
// - I/O level select bit 0, reset zero
// - Pump enable from pump control bit 7
// - Pump tracking field bits 5:4, reset 0x2
// - Six-bit half-rail threshold, reset 0xE
// - Threshold applies only for tracking 10, 11
// - Low two slave address bits writable
// - Optional bus timeout near 43.9 ms
// - Writing soft reset restores all defaults
// - Write mode 0 auto-increments register address
// - Write mode 1 takes address per byte
`timescale 1ns/1ns
module ccrb_bank import ccrb_pkg::*; #(
  // Upper five slave address bits; value is arbitrary
  parameter logic [4:0] DEV_ADDR_HI = 5'h0d,
  parameter int TIMEOUT_CYC = TIMEOUT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  output logic i2c_sda_out,
  output logic i2c_sda_oe_out,
  output logic mix_left_en_out,
  output logic mix_right_en_out,
  output logic io_level_sel_out,
  output logic pump_enable_out,
  output logic [1:0] pump_tracking_select_out,
  output logic [5:0] half_rail_threshold_out,
  output logic half_rail_threshold_active_out,
  output logic rate_split_out,
  output logic [3:0] sample_rate_out,
  output logic [1:0] gain_ramp_out,
  output logic [1:0] sample_sync_out,
  output logic [6:0] slave_addr_out,
  output logic bus_busy_out
);

  typedef struct packed {
    ccrb_state_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic rd_nw;
    logic nack;
    logic sda_oe;
    logic [TO_W-1:0] to_cnt;
    logic thr_active;
    logic busy;
    logic [NREG-1:0][7:0] regs;
  } ccrb_bank_state_t;

  ccrb_bank_state_t q_r;
  ccrb_bank_state_t q_nxt;

  logic [1:0] pins_f;
  logic scl_f;
  logic sda_f;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [6:0] own_addr;
  logic timeout_hit;
  logic [7:0] rd_byte;

  ccrb_sync #(
    .W(2)
  ) u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in({i2c_scl_in, i2c_sda_in}),
    .level_out(pins_f)
  );

  assign scl_f = pins_f[1];
  assign sda_f = pins_f[0];
  assign scl_rise = scl_f & ~q_r.scl_q;
  assign scl_fall = ~scl_f & q_r.scl_q;
  // Both conditions need SCL high on two samples in a row
  assign start_cond = scl_f & q_r.scl_q & q_r.sda_q & ~sda_f;
  assign stop_cond = scl_f & q_r.scl_q & ~q_r.sda_q & sda_f;
  assign own_addr = {DEV_ADDR_HI, q_r.regs[IDX_ADDR_CFG][ADDR_CFG_MSB:0]};
  assign timeout_hit = (q_r.to_cnt == TO_W'(TIMEOUT_CYC - 1));
  // Current pointer's read value, shared by both byte loaders
  assign rd_byte = read_reg(q_r.regs, q_r.ptr);

  // Unmapped offsets and reserved bits read as zero
  function automatic logic [7:0] read_reg(input logic [NREG-1:0][7:0] regs,
                                          input logic [7:0] ofs);
    logic [7:0] val;
    val = 8'h00;
    for (int i = 0; i < NREG; i++) begin
      if (ofs == REG_OFS[i]) begin
        val = regs[i];
      end
    end
    return val;
  endfunction : read_reg

  function automatic logic [NREG-1:0][7:0] write_reg(input logic [NREG-1:0][7:0] regs,
                                                      input logic [7:0] ofs,
                                                      input logic [7:0] data);
    logic [NREG-1:0][7:0] res;
    res = regs;
    for (int i = 0; i < NREG; i++) begin
      if (ofs == REG_OFS[i]) begin
        res[i] = data & REG_MASK[i];
      end
    end
    // Soft reset bit is not stored: it acts and reads back as zero
    if (ofs == REG_OFS[IDX_IF_CTRL] && data[SOFT_RESET_BIT]) begin
      res = REG_RST;
    end
    return res;
  endfunction : write_reg

  always_comb begin
    q_nxt = q_r;
    q_nxt.scl_q = scl_f;
    q_nxt.sda_q = sda_f;

    // Stall counter runs only while a transfer holds the clock low
    // Counter width holds the full default period
    if (q_r.regs[IDX_TIMEOUT][TIMEOUT_EN_BIT] && q_r.st != ST_IDLE && !scl_f) begin
      q_nxt.to_cnt = q_r.to_cnt + TO_W'(1);
    end else begin
      q_nxt.to_cnt = '0;
    end
    if (start_cond) begin
      // Repeated start is taken from any state
      q_nxt.st = ST_DEV_ADDR;
      q_nxt.bit_cnt = 4'h0;
      q_nxt.sda_oe = 1'b0;
    end else if (stop_cond) begin
      q_nxt.st = ST_IDLE;
      q_nxt.sda_oe = 1'b0;
    end else if (q_r.regs[IDX_TIMEOUT][TIMEOUT_EN_BIT] && timeout_hit) begin
      // Abandon the transfer and free the data line
      q_nxt.st = ST_IDLE;
      q_nxt.sda_oe = 1'b0;
      q_nxt.to_cnt = '0;
    end else if (scl_rise) begin
      case (q_r.st)
        ST_DEV_ADDR, ST_REG_ADDR, ST_WR_DATA: begin
          q_nxt.shift = {q_r.shift[6:0], sda_f};
          q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
        end
        ST_RD_DATA: begin
          q_nxt.bit_cnt = q_r.bit_cnt + 4'h1;
        end
        ST_RD_ACK: begin
          q_nxt.nack = sda_f;
        end
        ST_IDLE, ST_DEV_ACK, ST_REG_ACK, ST_WR_ACK: begin
          // Ack slots and idle shift nothing in
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (q_r.st)
        ST_IDLE: begin
          // Off the bus until the next start
          q_nxt.sda_oe = 1'b0;
        end
        ST_DEV_ADDR: begin
          // Byte complete after eight rising edges
          if (q_r.bit_cnt == BITS_PER_BYTE) begin
            if (q_r.shift[7:1] == own_addr) begin
              q_nxt.st = ST_DEV_ACK;
              q_nxt.rd_nw = q_r.shift[0];
              q_nxt.sda_oe = 1'b1;
            end else begin
              // Not ours: stay off the bus until the next start
              q_nxt.st = ST_IDLE;
            end
          end
        end
        ST_DEV_ACK: begin
          q_nxt.bit_cnt = 4'h0;
          if (q_r.rd_nw) begin
            q_nxt.st = ST_RD_DATA;
            q_nxt.shift = {rd_byte[6:0], 1'b0};
            q_nxt.sda_oe = ~rd_byte[7];
          end else begin
            q_nxt.st = ST_REG_ADDR;
            q_nxt.sda_oe = 1'b0;
          end
        end
        ST_REG_ADDR: begin
          if (q_r.bit_cnt == BITS_PER_BYTE) begin
            q_nxt.ptr = q_r.shift;
            q_nxt.st = ST_REG_ACK;
            q_nxt.sda_oe = 1'b1;
          end
        end
        ST_REG_ACK: begin
          // Data phase follows the register address
          q_nxt.st = ST_WR_DATA;
          q_nxt.bit_cnt = 4'h0;
          q_nxt.sda_oe = 1'b0;
        end
        ST_WR_DATA: begin
          // Write lands before the ack, so a later stop cannot lose it
          if (q_r.bit_cnt == BITS_PER_BYTE) begin
            q_nxt.regs = write_reg(q_r.regs, q_r.ptr, q_r.shift);
            if (!q_r.regs[IDX_IF_CTRL][WRITE_MODE_BIT]) begin
              q_nxt.ptr = q_r.ptr + 8'h01;
            end
            q_nxt.st = ST_WR_ACK;
            q_nxt.sda_oe = 1'b1;
          end
        end
        ST_WR_ACK: begin
          q_nxt.bit_cnt = 4'h0;
          q_nxt.sda_oe = 1'b0;
          // Repeat mode expects a fresh address before each data byte
          if (q_r.regs[IDX_IF_CTRL][WRITE_MODE_BIT]) begin
            q_nxt.st = ST_REG_ADDR;
          end else begin
            q_nxt.st = ST_WR_DATA;
          end
        end
        ST_RD_DATA: begin
          if (q_r.bit_cnt == BITS_PER_BYTE) begin
            q_nxt.st = ST_RD_ACK;
            q_nxt.sda_oe = 1'b0;
            q_nxt.ptr = q_r.ptr + 8'h01;
          end else begin
            q_nxt.sda_oe = ~q_r.shift[7];
            q_nxt.shift = {q_r.shift[6:0], 1'b0};
          end
        end
        ST_RD_ACK: begin
          q_nxt.bit_cnt = 4'h0;
          if (q_r.nack) begin
            q_nxt.st = ST_IDLE;
            q_nxt.sda_oe = 1'b0;
          end else begin
            // Master ack asks for the next byte
            q_nxt.st = ST_RD_DATA;
            q_nxt.shift = {rd_byte[6:0], 1'b0};
            q_nxt.sda_oe = ~rd_byte[7];
          end
        end
        default: begin
          q_nxt.sda_oe = 1'b0;
        end
      endcase
    end

    // Tracking codes 10 and 11 both have the upper bit set
    q_nxt.thr_active = q_nxt.regs[IDX_PUMP][TRACK_MSB];
    // Busy kept in a flop so the output comes straight from one
    q_nxt.busy = (q_nxt.st != ST_IDLE);
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_r.st <= ST_IDLE;
      q_r.scl_q <= 1'b1;
      q_r.sda_q <= 1'b1;
      q_r.bit_cnt <= 4'h0;
      q_r.shift <= 8'h00;
      q_r.ptr <= 8'h00;
      q_r.rd_nw <= 1'b0;
      q_r.nack <= 1'b0;
      q_r.sda_oe <= 1'b0;
      q_r.to_cnt <= '0;
      q_r.thr_active <= REG_RST[IDX_PUMP][TRACK_MSB];
      q_r.busy <= 1'b0;
      q_r.regs <= REG_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Open-drain: the line is only ever pulled low
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe_out = q_r.sda_oe;
  // Level outputs come straight from the bank flops
  assign mix_left_en_out = q_r.regs[IDX_MIX_L][MIX_EN_BIT];
  assign mix_right_en_out = q_r.regs[IDX_MIX_R][MIX_EN_BIT];
  assign io_level_sel_out = q_r.regs[IDX_IO_LEVEL][IO_LEVEL_BIT];
  assign pump_enable_out = q_r.regs[IDX_PUMP][PUMP_EN_BIT];
  assign pump_tracking_select_out = q_r.regs[IDX_PUMP][TRACK_MSB:TRACK_LSB];
  assign half_rail_threshold_out = q_r.regs[IDX_THRESHOLD][THRESH_MSB:0];
  assign half_rail_threshold_active_out = q_r.thr_active;
  assign rate_split_out = q_r.regs[IDX_RATE_SPLIT][RATE_SPLIT_BIT];
  assign sample_rate_out = q_r.regs[IDX_SAMPLE_RATE][RATE_MSB:0];
  assign gain_ramp_out = q_r.regs[IDX_GAIN_RAMP][RAMP_MSB:0];
  assign sample_sync_out = q_r.regs[IDX_SYNC][SYNC_MSB:0];
  assign slave_addr_out = {DEV_ADDR_HI, q_r.regs[IDX_ADDR_CFG][ADDR_CFG_MSB:0]};
  assign bus_busy_out = q_r.busy;

endmodule : ccrb_bank

// *** verification/ccrb_bank_asserts.sv ***
// Port-level checks for the codec control register bank
`timescale 1ns/1ns
module ccrb_bank_asserts #(
  parameter logic [4:0] DEV_ADDR_HI = 5'h0d
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic i2c_scl_in,
  input wire logic i2c_sda_in,
  input wire logic i2c_sda_out,
  input wire logic i2c_sda_oe_out,
  input wire logic mix_left_en_out,
  input wire logic mix_right_en_out,
  input wire logic io_level_sel_out,
  input wire logic pump_enable_out,
  input wire logic [1:0] pump_tracking_select_out,
  input wire logic [5:0] half_rail_threshold_out,
  input wire logic half_rail_threshold_active_out,
  input wire logic [6:0] slave_addr_out,
  input wire logic bus_busy_out
);
  wire logic [12:0] fields = {mix_left_en_out, mix_right_en_out, io_level_sel_out,
    pump_enable_out, pump_tracking_select_out, half_rail_threshold_out,
    half_rail_threshold_active_out};
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence bus_quiet;
    !bus_busy_out [*3];
  endsequence
  sequence start_cond;
    i2c_scl_in && !i2c_sda_in;
  endsequence
  sda_zero_a: assert property (i2c_sda_out == 1'b0)
    else $error("sda data output not zero");
  track_active_a: assert property (
    half_rail_threshold_active_out == pump_tracking_select_out[1])
    else $error("threshold active disagrees with tracking");
  addr_high_a: assert property (slave_addr_out[6:2] == DEV_ADDR_HI)
    else $error("upper slave address bits wrong");
  quiet_release_a: assert property (bus_quiet |-> !i2c_sda_oe_out)
    else $error("sda held while bus idle");
  oe_scl_low_a: assert property ($changed(i2c_sda_oe_out) |-> !i2c_scl_in)
    else $error("sda enable moved while scl high");
  field_scl_low_a: assert property ($changed(fields) |-> !i2c_scl_in)
    else $error("field changed while scl high");
  field_idle_a: assert property (!$past(bus_busy_out) |-> $stable(fields))
    else $error("field changed with no transfer");
  addr_busy_a: assert property ($changed(slave_addr_out) |-> $past(bus_busy_out))
    else $error("slave address changed with no transfer");
  busy_start_a: assert property ($rose(bus_busy_out) |-> start_cond)
    else $error("busy rose without start");
endmodule : ccrb_bank_asserts

bind ccrb_bank ccrb_bank_asserts #(.DEV_ADDR_HI(DEV_ADDR_HI)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .i2c_scl_in(i2c_scl_in), .i2c_sda_in(i2c_sda_in),
  .i2c_sda_out(i2c_sda_out), .i2c_sda_oe_out(i2c_sda_oe_out),
  .mix_left_en_out(mix_left_en_out), .mix_right_en_out(mix_right_en_out),
  .io_level_sel_out(io_level_sel_out), .pump_enable_out(pump_enable_out),
  .pump_tracking_select_out(pump_tracking_select_out),
  .half_rail_threshold_out(half_rail_threshold_out),
  .half_rail_threshold_active_out(half_rail_threshold_active_out),
  .slave_addr_out(slave_addr_out), .bus_busy_out(bus_busy_out));

// *** verification/ccrb_host.sv ***
// Host model driving the two-wire control bus
`timescale 1ns/1ns
module ccrb_host (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Phase length in clocks; raise it for a slow host
  int hp = 10;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask : wt
  task automatic start();
    sda_low_out = 1'b0;
    wt(hp);
    scl_out = 1'b1;
    wt(hp);
    sda_low_out = 1'b1;
    wt(hp);
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    wt(hp);
    sda_low_out = 1'b1;
    wt(hp);
    scl_out = 1'b1;
    wt(hp);
    sda_low_out = 1'b0;
    wt(hp);
  endtask : stop
  // Data moves mid-low so both setup and hold clear the sync delay
  task automatic bit_io(input logic b, output logic r);
    wt(hp);
    sda_low_out = ~b;
    wt(hp);
    scl_out = 1'b1;
    wt(hp);
    r = sda_in;
    scl_out = 1'b0;
  endtask : bit_io
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                      output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask : xfer
endmodule : ccrb_host

// *** verification/tb_codec_control_register_bank.sv ***
// Self-checking bench for the codec control register bank
`timescale 1ns/1ns
module tb_codec_control_register_bank;
  import ccrb_pkg::*;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic oe, low, scl, busy, ml, mr, io, pe, act, rs;
  logic [1:0] trk, gr, ps;
  logic [3:0] sr;
  logic [5:0] thr;
  logic [6:0] sa;
  logic [6:0] dev = 7'h36;
  int num_errors = 0;
  int cmp_count = 0;
  // Open-drain wire with pull-up
  wire sda = ~(low | oe);
  always #5 clk_in = ~clk_in;
  ccrb_host host (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(low));
  ccrb_bank #(.TIMEOUT_CYC(200)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .i2c_scl_in(scl), .i2c_sda_in(sda), .i2c_sda_out(), .i2c_sda_oe_out(oe),
    .mix_left_en_out(ml), .mix_right_en_out(mr), .io_level_sel_out(io),
    .pump_enable_out(pe), .pump_tracking_select_out(trk), .half_rail_threshold_out(thr),
    .half_rail_threshold_active_out(act), .rate_split_out(rs), .sample_rate_out(sr),
    .gain_ramp_out(gr), .sample_sync_out(ps), .slave_addr_out(sa), .bus_busy_out(busy));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tx(input logic [7:0] b, input logic ea);
    logic [7:0] r;
    logic a;
    host.xfer(b, 1'b1, r, a);
    chk("ack", {7'h0, ea}, {7'h0, a});
  endtask : tx
  task automatic wr(input logic [7:0] q[$]);
    host.start();
    tx({dev, 1'b0}, 1'b1);
    foreach (q[i]) tx(q[i], 1'b1);
    host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic a;
    wr('{ofs});
    host.start();
    tx({dev, 1'b1}, 1'b1);
    host.xfer(8'hff, 1'b1, d, a);
    host.stop();
  endtask : rd
  task automatic t_reset();
    logic [7:0] d;
    for (int i = 0; i < NREG; i++) begin
      rd(REG_OFS[i], d);
      chk("reset value", REG_RST[i], d);
    end
    rd(8'h20, d);
    chk("unmapped read", 8'h00, d);
    chk("reset outputs", 8'hb6, {act, sa});
    $display("reset test done");
  endtask : t_reset
  task automatic t_mask();
    logic [7:0] d;
    for (int i = 0; i < NREG; i++) begin
      if (i != IDX_IF_CTRL && i != IDX_ADDR_CFG) begin
        wr('{REG_OFS[i], 8'hff});
        rd(REG_OFS[i], d);
        chk("masked write", REG_MASK[i], d);
      end
    end
    chk("fields", 8'hff, {ml, mr, io, pe, trk, act, &thr});
    chk("rate fields", 8'h1f, {3'h0, rs, sr});
    chk("ramp sync", 8'h0f, {4'h0, gr, ps});
    wr('{8'h13, 8'h80});
    chk("soft reset", 8'h0a, {ml, mr, io, pe, trk, act, 1'b0});
    chk("threshold", 8'h0e, {2'h0, thr});
    chk("rate reset", 8'h0a, {3'h0, rs, sr});
    chk("ramp reset", 8'h02, {4'h0, gr, ps});
    rd(8'h13, d);
    chk("reset bit", 8'h00, d);
    $display("mask test done");
  endtask : t_mask
  task automatic t_page();
    host.hp = 20;
    wr('{8'h6e, 8'h80, 8'h80});
    host.hp = 10;
    chk("mixers", 8'h03, {6'h0, ml, mr});
    for (int c = 0; c < 4; c++) begin
      wr('{8'h47, {2'b10, 2'(c), 4'h0}});
      chk("tracking", {4'h0, 1'b1, 2'(c), c[1]}, {4'h0, pe, trk, act});
    end
    $display("page test done");
  endtask : t_page
  task automatic t_repeat();
    wr('{8'h13, 8'h01});
    wr('{8'h91, 8'h01, 8'h95, 8'h2a});
    chk("repeat mode", 8'hea, {1'b1, io, thr});
    wr('{8'h13, 8'h80});
    chk("soft reset", 8'h0e, {1'b0, io, thr});
    $display("repeat test done");
  endtask : t_repeat
  task automatic t_addr();
    logic [7:0] d;
    wr('{8'h1b, 8'h01}); // single device, so only it sees the clock
    chk("slave address", 8'h35, {1'b0, sa});
    host.start();
    tx({dev, 1'b0}, 1'b0);
    host.stop();
    dev = 7'h35;
    rd(8'h1b, d);
    chk("address cfg", 8'h01, d);
    wr('{8'h13, 8'h80});
    dev = 7'h36;
    chk("address reset", 8'h36, {1'b0, sa});
    $display("address test done");
  endtask : t_addr
  task automatic t_timeout();
    wr('{8'h12, 8'h01});
    host.start();
    tx({dev, 1'b0}, 1'b1);
    host.wt(300);
    chk("timeout on", 8'h00, {6'h0, busy, oe});
    host.stop();
    wr('{8'h13, 8'h80});
    host.start();
    tx({dev, 1'b0}, 1'b1);
    host.wt(300);
    chk("timeout off", 8'h02, {6'h0, busy, oe});
    host.stop();
    $display("timeout test done");
  endtask : t_timeout
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    repeat (95000) @(posedge clk_in);
    num_errors++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    rst_n_in = 1'b1;
    host.wt(4);
    t_reset();
    t_mask();
    t_page();
    t_repeat();
    t_addr();
    t_timeout();
    stop_test();
  end
endmodule : tb_codec_control_register_bank
